// [rtl/nfc_top.sv]
// notch filter coefficient control with an avalon-mm register slave
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module nfc_top
	import nfc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [NFC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [NFC_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [NFC_DATA_W-1:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest,
	output logic notch_enable,
	output logic [NFC_COEFF_W-1:0] notch_coeff_zero,
	output logic [NFC_COEFF_W-1:0] notch_coeff_one
);

	nfc_bus_state_t state;
	nfc_bus_state_t next_state;
	logic [NFC_DATA_W-1:0] next_readdata;
	logic [1:0] next_response;
	logic next_waitrequest;

	logic [NFC_NUM_REGS-1:0] reg_hit;
	logic status_hit;
	logic addr_hit;
	logic coeff_hit;
	logic wr_fire;
	logic req;
	logic [8:0] reg_q [NFC_NUM_REGS];
	logic [NFC_NUM_REGS-1:0] commit_bits;
	logic commit_any;
	logic [NFC_COEFF_W-1:0] staged_zero;
	logic [NFC_COEFF_W-1:0] staged_one;
	logic [NFC_DATA_W-1:0] rd_mux;

	// address decode: aligned word addresses only
	always_comb begin
		reg_hit[0] = (avs_address == NFC_ADDR_A0_HI);
		reg_hit[1] = (avs_address == NFC_ADDR_A0_LO);
		reg_hit[2] = (avs_address == NFC_ADDR_A1_HI);
		reg_hit[3] = (avs_address == NFC_ADDR_A1_LO);
		status_hit = (avs_address == NFC_ADDR_STATUS);
		coeff_hit = |reg_hit;
		addr_hit = coeff_hit | status_hit;
	end

	// a write lands on the edge where the master sees waitrequest low
	assign req = avs_read | avs_write;
	assign wr_fire = avs_write & (state == NFC_BUS_ACK);

	// four coefficient registers; the first also holds the filter enable
	generate
		for (genvar i = 0; i < NFC_NUM_REGS; i++) begin : g_reg
			nfc_coeff_reg #(
				.WMASK((i == 0) ? NFC_MASK_CTRL : NFC_MASK_COEFF),
				.RST_VAL(NFC_REG_RST)
			) u_reg (
				.mclk(mclk),
				.rst_n(rst_n),
				.we(wr_fire & reg_hit[i]),
				.be(avs_byteenable[1:0]),
				.wdata(avs_writedata[8:0]),
				.q(reg_q[i])
			);
			assign commit_bits[i] = reg_q[i][NFC_COMMIT_BIT]; // RL3
		end
	endgenerate

	// any one update bit is enough to start a load
	assign commit_any = |commit_bits; // RL3 RL5

	// staged coefficients, high seven bits first, two's complement
	assign staged_zero = {reg_q[0][NFC_HALF_W-1:0], reg_q[1][NFC_HALF_W-1:0]}; // RL2
	assign staged_one = {reg_q[2][NFC_HALF_W-1:0], reg_q[3][NFC_HALF_W-1:0]}; // RL2

	// filter enable is live, it needs no update pulse
	assign notch_enable = reg_q[0][NFC_ENABLE_BIT]; // RL1

	// active coefficient set driven to the filter
	nfc_commit #(
		.COEFF_W(NFC_COEFF_W)
	) u_commit (
		.mclk(mclk),
		.rst_n(rst_n),
		.commit_any(commit_any),
		.staged_zero(staged_zero),
		.staged_one(staged_one),
		.active_zero(notch_coeff_zero),
		.active_one(notch_coeff_one)
	);

	// read data selection; reserved bits read as zero
	always_comb begin
		rd_mux = '0;
		if (reg_hit[0]) begin
			rd_mux[8:0] = reg_q[0];
		end else if (reg_hit[1]) begin
			rd_mux[8:0] = reg_q[1];
		end else if (reg_hit[2]) begin
			rd_mux[8:0] = reg_q[2];
		end else if (reg_hit[3]) begin
			rd_mux[8:0] = reg_q[3];
		end else if (status_hit) begin
			rd_mux[NFC_ST_A0_LSB +: NFC_COEFF_W] = notch_coeff_zero;
			rd_mux[NFC_ST_A1_LSB +: NFC_COEFF_W] = notch_coeff_one;
			rd_mux[NFC_ST_BUSY_BIT] = commit_any;
		end
	end

	// bus handshake: one wait cycle, then one answer cycle
	always_comb begin
		next_state = state;
		next_readdata = avs_readdata;
		next_response = avs_response;
		next_waitrequest = 1'b1;
		case (state)
			NFC_BUS_IDLE: begin
				if (req) begin
					next_state = NFC_BUS_ACK;
					next_waitrequest = 1'b0;
					next_response = addr_hit ? NFC_RESP_OKAY : NFC_RESP_SLVERR;
					next_readdata = avs_read ? rd_mux : '0;
				end
			end
			NFC_BUS_ACK: begin
				next_state = NFC_BUS_IDLE;
			end
			default: begin
				next_state = NFC_BUS_IDLE;
			end
		endcase
	end

	// register the bus answer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= NFC_BUS_IDLE;
			avs_readdata <= '0;
			avs_response <= NFC_RESP_OKAY;
			avs_waitrequest <= 1'b1;
		end else begin
			state <= next_state;
			avs_readdata <= next_readdata;
			avs_response <= next_response;
			avs_waitrequest <= next_waitrequest;
		end
	end

	// checks on the bus answer and the coefficient path
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// the answer lasts exactly one cycle
	chk_answer_single: assert property (
		!avs_waitrequest |=> avs_waitrequest
	) else $error("waitrequest low for more than one cycle");

	// a new request is answered in the next cycle
	chk_answer_bound: assert property (
		req && avs_waitrequest && state == NFC_BUS_IDLE |=> !avs_waitrequest
	) else $error("request not answered after one cycle");

	// unmapped addresses get an error answer
	chk_unmapped_error: assert property (
		req && state == NFC_BUS_IDLE && !addr_hit |=>
			!avs_waitrequest && avs_response == NFC_RESP_SLVERR
	) else $error("unmapped access not answered with error");

	// a write of the enable bit reaches the filter one cycle later
	chk_enable_write: assert property ( // RL1
		wr_fire && reg_hit[0] && avs_byteenable[0] |=>
			notch_enable == $past(avs_writedata[NFC_ENABLE_BIT])
	) else $error("filter enable does not follow its write");

	// the enable holds when its register is not written
	chk_enable_hold: assert property ( // RL1
		!(wr_fire && reg_hit[0] && avs_byteenable[0]) |=> $stable(notch_enable)
	) else $error("filter enable changed without a write");

	// active coefficient is high field over low field, all fourteen bits
	chk_coeff_layout: assert property ( // RL2
		commit_any |=> notch_coeff_zero ==
			{$past(reg_q[0][NFC_HALF_W-1:0]), $past(reg_q[1][NFC_HALF_W-1:0])}
	) else $error("coefficient zero not assembled from its two fields");

	// setting the update bit of any coefficient register arms a load
	chk_update_bit: assert property ( // RL3
		wr_fire && coeff_hit && avs_byteenable[1] && avs_writedata[NFC_COMMIT_BIT] |=>
			commit_any ##1 (notch_coeff_one == $past(staged_one))
	) else $error("update bit write did not load the coefficients");

	// when the pulse ends, the filter holds the set seen during it
	chk_pulse_load: assert property ( // RL4
		$fell(commit_any) |->
			notch_coeff_zero == $past(staged_zero) && notch_coeff_one == $past(staged_one)
	) else $error("update pulse did not load both coefficients");

	// while an update bit stays high the filter keeps tracking staging
	chk_continuous_copy: assert property ( // RL5
		commit_any ##1 commit_any |=> notch_coeff_one == $past(staged_one)
	) else $error("coefficients not copied while update bit high");

	// staged writes do not disturb the active set
	chk_staging_hold: assert property ( // RL6
		!commit_any |=> $stable(notch_coeff_zero) && $stable(notch_coeff_one)
	) else $error("active coefficients changed without an update");

	// reserved bit 7 of the coefficient-only registers reads as zero
	chk_reserved_zero: assert property (
		reg_q[1][NFC_ENABLE_BIT] == 1'b0 && reg_q[2][NFC_ENABLE_BIT] == 1'b0 &&
			reg_q[3][NFC_ENABLE_BIT] == 1'b0
	) else $error("reserved coefficient register bit is set");

	// a write lands only at the edge where the master sees waitrequest low
	chk_write_lands: assert property (
		wr_fire |-> !avs_waitrequest && avs_write
	) else $error("register write outside the answer cycle");

	// waitrequest is low only in the answer state
	chk_ack_state: assert property (
		!avs_waitrequest |-> state == NFC_BUS_ACK
	) else $error("waitrequest low outside the answer state");

	// an idle slave always stalls the master
	chk_idle_stall: assert property (
		state == NFC_BUS_IDLE |-> avs_waitrequest
	) else $error("idle slave not holding waitrequest high");

	// mapped addresses get an okay answer
	chk_mapped_okay: assert property (
		req && state == NFC_BUS_IDLE && addr_hit |=>
			!avs_waitrequest && avs_response == NFC_RESP_OKAY
	) else $error("mapped access not answered with okay");

	// refused accesses return zero read data
	chk_unmapped_zero: assert property (
		req && state == NFC_BUS_IDLE && !addr_hit |=> avs_readdata == '0
	) else $error("refused access returned read data");

	// a write answer carries no read data
	chk_write_nodata: assert property (
		avs_write && state == NFC_BUS_IDLE |=> avs_readdata == '0
	) else $error("write answer carried read data");

	// read data and response stand until the next request is taken
	chk_answer_hold: assert property (
		!(req && state == NFC_BUS_IDLE) |=>
			$stable(avs_readdata) && $stable(avs_response)
	) else $error("bus answer changed without a request");

	// a read of the first register returns its stored bits, upper bits zero
	chk_read_first: assert property ( // RL1
		avs_read && state == NFC_BUS_IDLE && reg_hit[0] |=>
			avs_readdata == {23'h000000, $past(reg_q[0])}
	) else $error("first register read back wrong");

	// a read of the last coefficient register returns its stored bits
	chk_read_last: assert property ( // RL2
		avs_read && state == NFC_BUS_IDLE && reg_hit[3] |=>
			avs_readdata == {23'h000000, $past(reg_q[3])}
	) else $error("last coefficient register read back wrong");

	// status shows the active set and whether any update bit is high
	chk_status_read: assert property ( // RL5
		avs_read && state == NFC_BUS_IDLE && status_hit |=>
			avs_readdata[NFC_ST_BUSY_BIT] == $past(commit_any) &&
			avs_readdata[NFC_ST_A0_LSB +: NFC_COEFF_W] == $past(notch_coeff_zero) &&
			avs_readdata[NFC_ST_A1_LSB +: NFC_COEFF_W] == $past(notch_coeff_one)
	) else $error("status read does not match the active set");

	// writes that miss the coefficient registers leave them untouched
	chk_miss_nowrite: assert property (
		wr_fire && !coeff_hit |=> $stable(reg_q[0]) && $stable(reg_q[1]) &&
			$stable(reg_q[2]) && $stable(reg_q[3])
	) else $error("register changed on a refused write");

	// a low-lane write stores the coefficient field of its register
	chk_field_write: assert property ( // RL2
		wr_fire && reg_hit[1] && avs_byteenable[0] |=>
			reg_q[1][NFC_HALF_W-1:0] == $past(avs_writedata[NFC_HALF_W-1:0])
	) else $error("coefficient field write did not land");

	// the update bit of a register follows a write of its upper lane
	chk_commit_write: assert property ( // RL3
		wr_fire && reg_hit[2] && avs_byteenable[1] |=>
			reg_q[2][NFC_COMMIT_BIT] == $past(avs_writedata[NFC_COMMIT_BIT])
	) else $error("update bit write did not land");

	// both coefficients load on the same edge
	chk_pair_load: assert property ( // RL4
		commit_any |=> notch_coeff_zero == $past(staged_zero) &&
			notch_coeff_one == $past(staged_one)
	) else $error("coefficients did not load together");

	// an active coefficient only changes after an edge with an update bit high
	chk_change_cause: assert property ( // RL6
		$changed(notch_coeff_zero) || $changed(notch_coeff_one) |-> $past(commit_any)
	) else $error("active coefficients moved without an update bit");

endmodule

// [rtl/nfc_pkg.sv]
// constants for the notch filter coefficient control block
// Contract
// RL1: notch filtering is applied only while enable bit 7 of the first register is high.
// RL2: each coefficient is a 14-bit two's-complement value, bits 13 down to 0.
// RL3: bit 8 of all four coefficient registers is an update bit.
// RL4: a low-high-low pulse on one update bit loads all coefficients together.
// RL5: while any update bit stays high, coefficients are copied to the filter continuously.
// RL6: writes with all update bits low stay staged until the next update.
package nfc_pkg;

	// register indices, byte address is four times the index
	localparam logic [7:0] NFC_IDX_A0_HI = 8'h3b;
	localparam logic [7:0] NFC_IDX_A0_LO = 8'h3c;
	localparam logic [7:0] NFC_IDX_A1_HI = 8'h3d;
	localparam logic [7:0] NFC_IDX_A1_LO = 8'h3e;
	localparam logic [7:0] NFC_IDX_STATUS = 8'h3f;
	localparam logic [7:0] NFC_ADDR_A0_HI = {NFC_IDX_A0_HI[5:0], 2'b00};
	localparam logic [7:0] NFC_ADDR_A0_LO = {NFC_IDX_A0_LO[5:0], 2'b00};
	localparam logic [7:0] NFC_ADDR_A1_HI = {NFC_IDX_A1_HI[5:0], 2'b00};
	localparam logic [7:0] NFC_ADDR_A1_LO = {NFC_IDX_A1_LO[5:0], 2'b00};
	localparam logic [7:0] NFC_ADDR_STATUS = {NFC_IDX_STATUS[5:0], 2'b00};

	// coefficient register layout
	localparam int NFC_NUM_REGS = 4;
	localparam int NFC_REG_W = 9;
	localparam int NFC_COMMIT_BIT = 8;
	localparam int NFC_ENABLE_BIT = 7;
	localparam int NFC_HALF_W = 7;
	localparam int NFC_COEFF_W = 14;
	localparam logic [8:0] NFC_REG_RST = 9'h000;
	localparam logic [8:0] NFC_MASK_CTRL = 9'h1ff;
	localparam logic [8:0] NFC_MASK_COEFF = 9'h17f;

	// status register fields
	localparam int NFC_ST_A0_LSB = 0;
	localparam int NFC_ST_A1_LSB = 16;
	localparam int NFC_ST_BUSY_BIT = 31;

	// bus widths and answers
	localparam int NFC_ADDR_W = 8;
	localparam int NFC_DATA_W = 32;
	localparam logic [1:0] NFC_RESP_OKAY = 2'h0;
	localparam logic [1:0] NFC_RESP_SLVERR = 2'h2;

	typedef enum logic {
		NFC_BUS_IDLE,
		NFC_BUS_ACK
	} nfc_bus_state_t;

endpackage

// [rtl/nfc_coeff_reg.sv]
// one nine-bit control register with byte-lane writes and a write mask
`timescale 1ns/100ps
module nfc_coeff_reg
	import nfc_pkg::*;
#(
	parameter logic [8:0] WMASK = NFC_MASK_COEFF,
	parameter logic [8:0] RST_VAL = NFC_REG_RST
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [8:0] wdata,
	output logic [8:0] q
);

	logic [8:0] next_q;

	// low lane writes bits 7:0, next lane the update bit; masked bits stay zero
	always_comb begin
		next_q = q;
		if (we) begin
			if (be[0]) begin
				next_q[7:0] = wdata[7:0] & WMASK[7:0];
			end
			if (be[1]) begin
				next_q[8] = wdata[8] & WMASK[8];
			end
		end
	end

	// register the value
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST_VAL;
		end else begin
			q <= next_q;
		end
	end

endmodule

// [rtl/nfc_commit.sv]
// active coefficient set, loaded from staging while an update bit is high
`timescale 1ns/100ps
module nfc_commit
	import nfc_pkg::*;
#(
	parameter int COEFF_W = NFC_COEFF_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic commit_any,
	input wire logic [COEFF_W-1:0] staged_zero,
	input wire logic [COEFF_W-1:0] staged_one,
	output logic [COEFF_W-1:0] active_zero,
	output logic [COEFF_W-1:0] active_one
);

	logic [COEFF_W-1:0] next_zero;
	logic [COEFF_W-1:0] next_one;

	// both coefficients move together, never one without the other
	always_comb begin
		next_zero = active_zero;
		next_one = active_one;
		if (commit_any) begin // RL4 RL5
			next_zero = staged_zero;
			next_one = staged_one;
		end
	end

	// hold the active set; staged writes wait here until an update
	always_ff @(posedge mclk or negedge rst_n) begin // RL6
		if (!rst_n) begin
			active_zero <= '0;
			active_one <= '0;
		end else begin
			active_zero <= next_zero;
			active_one <= next_one;
		end
	end

endmodule

// [verification/tb_top.sv]
// self-checking testbench for the notch filter coefficient control block
`timescale 1ns/100ps
module tb_top
	import nfc_pkg::*;
();
	logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, notch_enable;
	logic [NFC_ADDR_W-1:0] avs_address;
	logic [NFC_DATA_W-1:0] avs_writedata, avs_readdata, rdata;
	logic [3:0] avs_byteenable;
	logic [1:0] avs_response, resp;
	logic [NFC_COEFF_W-1:0] notch_coeff_zero, notch_coeff_one, cz, co;
	int n_mismatch, total_checks;

	nfc_top nfc_top_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
		.notch_enable(notch_enable), .notch_coeff_zero(notch_coeff_zero),
		.notch_coeff_one(notch_coeff_one));

	// 25 MHz clock
	always #20 mclk = ~mclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [8:0] d);
		avs_address <= a;
		avs_writedata <= {23'h000000, d};
		avs_byteenable <= 4'h3;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		resp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic c, input logic e, input logic [6:0] f);
		xfer(1'b1, a, {c, e, f});
		chk(resp, NFC_RESP_OKAY);
	endtask

	// stage both coefficients with every update bit low
	task automatic put(input logic [13:0] z, input logic [13:0] o);
		wr(NFC_ADDR_A0_HI, 1'b0, 1'b1, z[13:7]);
		wr(NFC_ADDR_A0_LO, 1'b0, 1'b0, z[6:0]);
		wr(NFC_ADDR_A1_HI, 1'b0, 1'b0, o[13:7]);
		wr(NFC_ADDR_A1_LO, 1'b0, 1'b0, o[6:0]);
	endtask

	task automatic settle();
		repeat (2) @(posedge mclk);
	endtask

	task automatic t_enable();
		wr(NFC_ADDR_A0_HI, 1'b0, 1'b1, 7'h00);
		settle();
		chk(notch_enable, 1'b1);
		wr(NFC_ADDR_A0_HI, 1'b0, 1'b0, 7'h00);
		settle();
		chk(notch_enable, 1'b0);
	endtask

	// commit through each of the four update bits in turn
	task automatic t_commit();
		logic [13:0] z, o;
		logic [7:0] ad [4];
		logic [6:0] f [4];
		ad = '{NFC_ADDR_A0_HI, NFC_ADDR_A0_LO, NFC_ADDR_A1_HI, NFC_ADDR_A1_LO};
		for (int i = 0; i < 4; i++) begin
			z = 14'h3ffd - 14'(i * 300);
			o = 14'h1a5c ^ 14'(i * 777);
			f = '{z[13:7], z[6:0], o[13:7], o[6:0]};
			put(z, o);
			settle();
			chk({notch_coeff_one, notch_coeff_zero}, {co, cz});
			chk(notch_enable, 1'b1);
			wr(ad[i], 1'b1, i == 0, f[i]);
			wr(ad[i], 1'b0, i == 0, f[i]);
			settle();
			chk({notch_coeff_one, notch_coeff_zero}, {o, z});
			cz = z;
			co = o;
			xfer(1'b0, NFC_ADDR_STATUS, 9'h000);
			chk(rdata, {2'b00, o, 2'b00, z});
			chk(resp, NFC_RESP_OKAY);
			xfer(1'b0, ad[i], 9'h000);
			chk(rdata, {23'h000000, 1'b0, (i == 0) ? 1'b1 : 1'b0, f[i]});
		end
	endtask

	// update bit left high keeps copying, clearing it freezes the set
	task automatic t_contin();
		wr(NFC_ADDR_A1_HI, 1'b1, 1'b0, co[13:7]);
		wr(NFC_ADDR_A0_LO, 1'b0, 1'b0, 7'h2a);
		wr(NFC_ADDR_A1_LO, 1'b0, 1'b0, 7'h11);
		settle();
		cz = {cz[13:7], 7'h2a};
		co = {co[13:7], 7'h11};
		chk({notch_coeff_one, notch_coeff_zero}, {co, cz});
		xfer(1'b0, NFC_ADDR_STATUS, 9'h000);
		chk(rdata[NFC_ST_BUSY_BIT], 1'b1);
		wr(NFC_ADDR_A1_HI, 1'b0, 1'b0, co[13:7]);
		wr(NFC_ADDR_A0_LO, 1'b0, 1'b0, 7'h55);
		settle();
		chk({notch_coeff_one, notch_coeff_zero}, {co, cz});
		xfer(1'b0, NFC_ADDR_STATUS, 9'h000);
		chk(rdata[NFC_ST_BUSY_BIT], 1'b0);
	endtask

	// unmapped read and misaligned write are refused and change nothing
	task automatic t_refuse();
		xfer(1'b0, 8'h00, 9'h000);
		chk(resp, NFC_RESP_SLVERR);
		chk(rdata, 32'h00000000);
		xfer(1'b1, NFC_ADDR_A0_HI + 8'h01, 9'h100);
		chk(resp, NFC_RESP_SLVERR);
		settle();
		chk({notch_coeff_one, notch_coeff_zero}, {co, cz});
		chk(notch_enable, 1'b1);
	endtask

	// reset in mid-run clears every register and the active set
	task automatic t_reset();
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(avs_waitrequest, 1'b1);
		chk({notch_enable, notch_coeff_one, notch_coeff_zero}, 32'h00000000);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		xfer(1'b0, NFC_ADDR_A0_HI, 9'h000);
		chk(rdata, 32'h00000000);
		chk(resp, NFC_RESP_OKAY);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog against a hung bus
	initial begin
		#200000;
		n_mismatch++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		wrap_up();
	end

	// reset, then the scenarios
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		cz = 14'h0000;
		co = 14'h0000;
		n_mismatch = 0;
		total_checks = 0;
		repeat (5) @(posedge mclk);
		chk(avs_waitrequest, 1'b1);
		chk({notch_enable, notch_coeff_one, notch_coeff_zero}, 32'h00000000);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_enable();
		t_commit();
		t_contin();
		t_refuse();
		t_reset();
		wrap_up();
	end
endmodule
